// ### dmdc_bus_model.sv
`timescale 1ns/1ps
module dmdc_bus_model (
    // Clock
    input  wire logic            clk_in,
    // Bus controller side
    output dmdc_pkg::dmdc_addr_t addr_out,
    output logic                 ale_out,
    output logic                 ram_ale_out,
    output logic                 fast_out
);
    import dmdc_pkg::*;
    initial begin
        addr_out = 24'h00_0000;
        ale_out = 1'b0;
        ram_ale_out = 1'b0;
        fast_out = 1'b0;
    end
    task automatic cycle(input dmdc_addr_t a, input logic fast);
        @(posedge clk_in) #1;
        fast_out = fast;
        addr_out = a;
        ale_out = !fast;
        ram_ale_out = 1'b1;
        @(posedge clk_in) #1;
        ale_out = 1'b0;
        ram_ale_out = 1'b0;
        // Address no longer valid once latched
        addr_out = ~a;
    endtask : cycle
endmodule : dmdc_bus_model

// ### dmdc_cfg_table.sv
`timescale 1ns/1ps
`include "dmdc_map.svh"
module dmdc_cfg_table (
    // Selection
    input  wire logic               cfg_in,
    input  wire dmdc_pkg::dmdc_cfg_t sel_in,
    input  wire dmdc_pkg::dmdc_addr_t addr_in,
    // Result
    output dmdc_pkg::dmdc_map_s     map_out
);
    import dmdc_pkg::*;
    logic [3:0] mb;
    logic [3:0] k64;
    logic       in_ram;
    // Table of five configurations; codes above four map nothing
    // five configurations
    always_comb begin
        mb      = addr_in[`DMDC_MB_HI:`DMDC_MB_LO];
        k64     = addr_in[`DMDC_K64_HI:`DMDC_K64_LO];
        in_ram  = (mb == 4'h0) && (k64 < `DMDC_K640_TOP);
        map_out = '0;
        map_out.ma8 = addr_in[`DMDC_MA8_BIT];
        map_out.ma9 = addr_in[`DMDC_MA9_BIT];
        if (cfg_in) begin
            unique case (sel_in)
                3'h0: begin
                    map_out.bank_lo = (mb == 4'h0)
                                      && (k64 < `DMDC_K256_TOP);
                end
                3'h1: begin
                    map_out.bank_lo = (mb == 4'h0)
                                      && (k64 < `DMDC_K512_TOP);
                end
                3'h2: begin
                    map_out.bank_lo = (mb == 4'h0)
                                      && (k64 < `DMDC_K512_TOP);
                    // Second bank only fills up to 640k
                    map_out.bank_hi = in_ram
                                      && (k64 >= `DMDC_K512_TOP);
                end
                3'h3: begin
                    map_out.bank_lo = in_ram;
                    map_out.bank_hi = (mb == 4'h1) || (mb == 4'h2)
                                      || (mb == 4'h3);
                    map_out.ma9     = mb[1];
                    map_out.ma8     = mb[0] | addr_in[`DMDC_MA8_BIT];
                end
                3'h4: begin
                    map_out.bank_lo = in_ram;
                    map_out.bank_hi = (mb == 4'h1);
                end
                default: map_out = '0;
            endcase
        end
    end
endmodule : dmdc_cfg_table

// ### dmdc_map.svh
`ifndef DMDC_MAP_SVH
`define DMDC_MAP_SVH
// Address field positions within the latched 24-bit bus address
`define DMDC_ADDR_W        24
`define DMDC_MB_LO         20
`define DMDC_MB_HI         23
`define DMDC_K64_LO        16
`define DMDC_K64_HI        19
`define DMDC_A20_BIT       20
`define DMDC_MA8_BIT       17
`define DMDC_MA9_BIT       18
// Region codes in 64k units inside the first megabyte
`define DMDC_K256_TOP      4'h4
`define DMDC_K512_TOP      4'h8
`define DMDC_K640_TOP      4'hA
`define DMDC_ROM_BASE      4'hE
// Number of configurations and select width
`define DMDC_CFG_W         3
`define DMDC_CFG_NUM       8
// Reset values
`define DMDC_ADDR_RST      24'h00_0000
`define DMDC_CFG_RST       3'h0
`endif

// ### dmdc_pkg.sv
package dmdc_pkg;
    `include "dmdc_map.svh"
    typedef logic [`DMDC_ADDR_W-1:0] dmdc_addr_t;
    typedef logic [`DMDC_CFG_W-1:0]  dmdc_cfg_t;
    typedef enum logic [1:0] {
        DMDC_IDLE  = 2'b00,
        DMDC_CYCLE = 2'b01,
        DMDC_REFR  = 2'b10
    } dmdc_state_e;
    // Bank decision for one access
    typedef struct packed {
        logic bank_lo;
        logic bank_hi;
        logic ma8;
        logic ma9;
    } dmdc_map_s;
endpackage : dmdc_pkg

// ### dmdc_top.sv
`timescale 1ns/1ps
`include "dmdc_map.svh"
module dmdc_top (
    // Clock, reset, enable
    input  wire logic                 MCLK_IN,
    input  wire logic                 SRST_IN,
    input  wire logic                 CE_IN,
    // CPU side
    input  wire dmdc_pkg::dmdc_addr_t CPU_ADDR_IN,
    input  wire logic                 ADDR_LATCH_STROBE_IN,
    input  wire logic                 RAM_LATCH_STROBE_IN,
    input  wire logic                 FAST_TIMING_MODE_IN,
    input  wire logic                 CPU_ADDR_BIT20_IN,
    input  wire logic                 ADDR_BIT20_GATE_IN,
    input  wire logic                 CPU_HOLD_ACK_IN,
    input  wire logic                 MEM_READ_IN,
    input  wire logic                 MEM_WORD_IN,
    // System and slot side
    input  wire logic                 DMA_ADDR_ACTIVE_N_IN,
    input  wire logic                 BUS_OWNER_N_IN,
    input  wire logic                 PERIPH_ADDR_BIT16_IN,
    input  wire logic                 REFRESH_REQ_N_IN,
    input  wire logic                 REFRESH_ROW_BIT9_IN,
    input  wire logic                 TIMER_CH2_LEVEL_IN,
    input  wire logic                 CHANNEL_CHECK_N_IN,
    input  wire logic                 PARITY_FAULT_N_IN,
    input  wire logic                 NMI_ENABLE_IN,
    input  wire logic                 PARITY_CHECK_ON_IN,
    // Configuration straps
    input  wire logic                 RAM_CONFIG_SEL_BIT0_IN,
    input  wire logic                 RAM_CONFIG_SEL_BIT1_IN,
    input  wire logic                 RAM_CONFIG_SEL_BIT2_IN,
    // Memory outputs
    output logic                      ROW_STROBE_BANK_LO_OUT,
    output logic                      ROW_STROBE_BANK_HI_OUT,
    output logic                      COL_STROBE_BANK_LO_OUT,
    output logic                      COL_STROBE_BANK_HI_OUT,
    output logic                      PARITY_CHECK_ENABLE_OUT,
    output logic                      DRAM_ADDR_BIT8_OUT,
    output logic                      DRAM_ADDR_BIT9_OUT,
    output logic                      MEM_DATA_DIRECTION_N_OUT,
    output logic                      WORD_ACCESS_FLAG_OUT,
    // Selects and slot address
    output logic                      LOW_MEG_SELECT_N_OUT,
    output logic                      ROM_SELECT_LOW_N_OUT,
    output logic                      ROM_SELECT_HIGH_N_OUT,
    output logic                      GATED_ADDR_BIT20_OUT,
    output logic [6:0]                SLOT_ADDR_HI_OUT,
    output logic                      SLOT_ADDR_OE_OUT,
    output logic                      ADDR_ENABLE_OUT,
    // Status readback and NMI
    output logic [7:0]                CTRL_READBACK_OUT,
    output logic                      NMI_OUT
);
    import dmdc_pkg::*;

    // Two-flop synchronisers for seven of the pin inputs
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync_d;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s1_next;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s2_next;
    assign sync_d = {REFRESH_REQ_N_IN, TIMER_CH2_LEVEL_IN,
                     CHANNEL_CHECK_N_IN, PARITY_FAULT_N_IN,
                     BUS_OWNER_N_IN, DMA_ADDR_ACTIVE_N_IN,
                     PERIPH_ADDR_BIT16_IN};
    logic refresh_n_s;
    logic timer_s;
    logic chk_n_s;
    logic par_n_s;
    logic owner_n_s;
    logic dma_n_s;
    logic periph_addr_bit16_s;
    assign {refresh_n_s, timer_s, chk_n_s, par_n_s, owner_n_s,
            dma_n_s, periph_addr_bit16_s} = s2_reg;

    // Strobe edge detection and latched state
    dmdc_state_e state_reg;
    dmdc_state_e state_next;
    dmdc_addr_t  addr_reg;
    dmdc_addr_t  addr_next;
    dmdc_cfg_t   cfg_reg;
    dmdc_cfg_t   cfg_next;
    logic        ale_d_reg;
    logic        ale_d_next;
    logic        rom_lo_reg;
    logic        rom_lo_next;
    logic        rom_hi_reg;
    logic        rom_hi_next;
    logic        nmi_reg;
    logic        nmi_next;
    logic        cfg_ok_reg;
    logic        cfg_ok_next;
    logic        latch_src;
    logic        ale_rise;
    logic        rom_hit;
    dmdc_map_s   map;

    dmdc_cfg_table u_table (
        .cfg_in  (cfg_ok_reg),
        .sel_in  (cfg_reg),
        .addr_in (addr_reg),
        .map_out (map)
    );

    function automatic logic is_rom(input dmdc_addr_t a);
        is_rom = (a[`DMDC_MB_HI:`DMDC_MB_LO] == 4'h0)
                 && (a[`DMDC_K64_HI:`DMDC_K64_LO] >= `DMDC_ROM_BASE);
    endfunction : is_rom

    always_comb begin
        s1_next     = sync_d;
        s2_next     = s1_reg;
        latch_src   = FAST_TIMING_MODE_IN ? RAM_LATCH_STROBE_IN
                                          : ADDR_LATCH_STROBE_IN;
        ale_d_next  = latch_src;
        ale_rise    = latch_src && !ale_d_reg;
        state_next  = state_reg;
        addr_next   = addr_reg;
        rom_lo_next = rom_lo_reg;
        rom_hi_next = rom_hi_reg;
        cfg_next    = cfg_reg;
        cfg_ok_next = cfg_ok_reg;
        if (!cfg_ok_reg) begin
            cfg_next    = {RAM_CONFIG_SEL_BIT2_IN, RAM_CONFIG_SEL_BIT1_IN,
                           RAM_CONFIG_SEL_BIT0_IN};
            cfg_ok_next = 1'b1;
        end
        rom_hit = is_rom(CPU_ADDR_IN);
        unique case (state_reg)
            DMDC_IDLE, DMDC_CYCLE: begin
                if (!refresh_n_s) begin
                    state_next = DMDC_REFR;
                end else if (ale_rise) begin
                    state_next  = DMDC_CYCLE;
                    addr_next   = CPU_ADDR_IN;
                    rom_lo_next = rom_hit && !periph_addr_bit16_s;
                    rom_hi_next = rom_hit && periph_addr_bit16_s;
                end
            end
            DMDC_REFR: begin
                if (refresh_n_s) begin
                    state_next = DMDC_IDLE;
                end
            end
            default: state_next = DMDC_IDLE;
        endcase
        nmi_next = NMI_ENABLE_IN && (!chk_n_s
                   || (!par_n_s && PARITY_CHECK_ON_IN));
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            s1_reg     <= '1;
            s2_reg     <= '1;
            state_reg  <= DMDC_IDLE;
            addr_reg   <= `DMDC_ADDR_RST;
            cfg_reg    <= `DMDC_CFG_RST;
            cfg_ok_reg <= 1'b0;
            ale_d_reg  <= 1'b0;
            rom_lo_reg <= 1'b0;
            rom_hi_reg <= 1'b0;
            nmi_reg    <= 1'b0;
        end else if (CE_IN) begin
            s1_reg     <= s1_next;
            s2_reg     <= s2_next;
            state_reg  <= state_next;
            addr_reg   <= addr_next;
            cfg_reg    <= cfg_next;
            cfg_ok_reg <= cfg_ok_next;
            ale_d_reg  <= ale_d_next;
            rom_lo_reg <= rom_lo_next;
            rom_hi_reg <= rom_hi_next;
            nmi_reg    <= nmi_next;
        end
    end

    logic in_cycle;
    logic in_refr;
    assign in_cycle = (state_reg == DMDC_CYCLE);
    assign in_refr  = (state_reg == DMDC_REFR);

    always_comb begin
        ROW_STROBE_BANK_LO_OUT = in_refr || (in_cycle && map.bank_lo);
        ROW_STROBE_BANK_HI_OUT = in_refr || (in_cycle && map.bank_hi);
        COL_STROBE_BANK_LO_OUT = in_cycle && map.bank_lo;
        COL_STROBE_BANK_HI_OUT = in_cycle && map.bank_hi;
        PARITY_CHECK_ENABLE_OUT = COL_STROBE_BANK_LO_OUT
                                  || COL_STROBE_BANK_HI_OUT;
        // refresh bit 9 onto bit 8
        DRAM_ADDR_BIT8_OUT = in_refr ? REFRESH_ROW_BIT9_IN : map.ma8;
        DRAM_ADDR_BIT9_OUT = map.ma9;
        MEM_DATA_DIRECTION_N_OUT = MEM_READ_IN;
        WORD_ACCESS_FLAG_OUT = in_cycle && MEM_WORD_IN
                               && (map.bank_lo || map.bank_hi);
        LOW_MEG_SELECT_N_OUT = !(in_cycle
            && addr_reg[`DMDC_MB_HI:`DMDC_MB_LO] == 4'h0);
        ROM_SELECT_LOW_N_OUT  = !(in_cycle && rom_lo_reg);
        ROM_SELECT_HIGH_N_OUT = !(in_cycle && rom_hi_reg);
        GATED_ADDR_BIT20_OUT = CPU_ADDR_BIT20_IN && ADDR_BIT20_GATE_IN;
        SLOT_ADDR_HI_OUT = addr_reg[`DMDC_MB_HI:`DMDC_MA8_BIT];
        SLOT_ADDR_OE_OUT = owner_n_s;
        ADDR_ENABLE_OUT = owner_n_s && !CPU_HOLD_ACK_IN && dma_n_s;
        CTRL_READBACK_OUT = {!par_n_s, !chk_n_s, timer_s, 5'h00};
        NMI_OUT = nmi_reg;
    end
endmodule : dmdc_top

// ### dmdc_top_props.sv
`timescale 1ns/1ps
module dmdc_top_props (
    // Inputs
    input wire logic MCLK_IN, SRST_IN, CE_IN,
    input wire dmdc_pkg::dmdc_addr_t CPU_ADDR_IN,
    input wire logic ADDR_LATCH_STROBE_IN, RAM_LATCH_STROBE_IN,
    input wire logic FAST_TIMING_MODE_IN, MEM_READ_IN,
    input wire logic CPU_ADDR_BIT20_IN, ADDR_BIT20_GATE_IN,
    input wire logic REFRESH_REQ_N_IN, REFRESH_ROW_BIT9_IN,
    input wire logic TIMER_CH2_LEVEL_IN, CHANNEL_CHECK_N_IN, NMI_ENABLE_IN,
    // Outputs
    input wire logic ROW_STROBE_BANK_LO_OUT, ROW_STROBE_BANK_HI_OUT,
    input wire logic COL_STROBE_BANK_LO_OUT, COL_STROBE_BANK_HI_OUT,
    input wire logic PARITY_CHECK_ENABLE_OUT, DRAM_ADDR_BIT8_OUT,
    input wire logic MEM_DATA_DIRECTION_N_OUT, GATED_ADDR_BIT20_OUT,
    input wire logic [6:0] SLOT_ADDR_HI_OUT,
    input wire logic [7:0] CTRL_READBACK_OUT,
    input wire logic NMI_OUT
);
    import dmdc_pkg::*;
    logic [2:0] rhi_reg, rhi_next;
    logic       src, src_d_reg, rise, acc;
    logic [6:0] addr_hi;
    assign src = FAST_TIMING_MODE_IN ? RAM_LATCH_STROBE_IN
                                     : ADDR_LATCH_STROBE_IN;
    assign rise = src && !src_d_reg;
    assign addr_hi = CPU_ADDR_IN[23:17];
    // Refresh must have left the sync flops first
    assign acc = rise && CE_IN && REFRESH_REQ_N_IN && rhi_reg == 3'h7;
    always_comb begin
        rhi_next = rhi_reg + {2'h0, rhi_reg != 3'h7};
        if (!REFRESH_REQ_N_IN) begin
            rhi_next = 3'h0;
        end
    end
    always_ff @(posedge MCLK_IN) begin
        rhi_reg <= SRST_IN ? 3'h0 : rhi_next;
        src_d_reg <= SRST_IN ? 1'b1 : src;
    end
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);
    AST_ADDR_LATCH: assert property (
        acc |=> SLOT_ADDR_HI_OUT == $past(addr_hi))
        else $error("slot address not latched");
    AST_ADDR_HOLD: assert property (
        !rise |=> $stable(SLOT_ADDR_HI_OUT))
        else $error("slot address moved without strobe");
    AST_REFRESH: assert property (
        (!REFRESH_REQ_N_IN && CE_IN) [*6] |-> ROW_STROBE_BANK_LO_OUT
        && ROW_STROBE_BANK_HI_OUT && !PARITY_CHECK_ENABLE_OUT)
        else $error("refresh strobes wrong");
    AST_REF_BIT8: assert property (
        !REFRESH_REQ_N_IN [*6] |-> DRAM_ADDR_BIT8_OUT == REFRESH_ROW_BIT9_IN)
        else $error("refresh bit not on dram bit 8");
    AST_A20_GATE: assert property (
        GATED_ADDR_BIT20_OUT == (CPU_ADDR_BIT20_IN && ADDR_BIT20_GATE_IN))
        else $error("bit 20 gating wrong");
    AST_DIR: assert property (
        MEM_DATA_DIRECTION_N_OUT == MEM_READ_IN)
        else $error("data direction wrong");
    AST_PARITY_CHECK_ENABLE: assert property (
        PARITY_CHECK_ENABLE_OUT == (COL_STROBE_BANK_LO_OUT
        || COL_STROBE_BANK_HI_OUT))
        else $error("parity enable not column OR");
    AST_TIMER_RB: assert property (
        ($stable(TIMER_CH2_LEVEL_IN) && CE_IN) [*4]
        |-> CTRL_READBACK_OUT[5] == TIMER_CH2_LEVEL_IN)
        else $error("timer level not readable");
    AST_NMI_ON: assert property (
        (!CHANNEL_CHECK_N_IN && NMI_ENABLE_IN && CE_IN) [*5] |-> NMI_OUT)
        else $error("channel check gave no NMI");
    AST_NMI_OFF: assert property (
        !NMI_ENABLE_IN [*3] |-> !NMI_OUT)
        else $error("NMI while disabled");
endmodule : dmdc_top_props
bind dmdc_top dmdc_top_props i_props (.*);

// ### dmdc_top_test.sv
`timescale 1ns/1ps
module dmdc_top_test;
    import dmdc_pkg::*;
    logic MCLK_IN = 1'b0;
    logic SRST_IN, CE_IN, CPU_ADDR_BIT20_IN, ADDR_BIT20_GATE_IN;
    logic CPU_HOLD_ACK_IN, MEM_READ_IN, MEM_WORD_IN, DMA_ADDR_ACTIVE_N_IN;
    logic BUS_OWNER_N_IN, PERIPH_ADDR_BIT16_IN, REFRESH_REQ_N_IN;
    logic REFRESH_ROW_BIT9_IN, TIMER_CH2_LEVEL_IN, CHANNEL_CHECK_N_IN;
    logic PARITY_FAULT_N_IN, NMI_ENABLE_IN, PARITY_CHECK_ON_IN;
    logic RAM_CONFIG_SEL_BIT0_IN, RAM_CONFIG_SEL_BIT1_IN;
    logic RAM_CONFIG_SEL_BIT2_IN, ADDR_LATCH_STROBE_IN;
    logic RAM_LATCH_STROBE_IN, FAST_TIMING_MODE_IN;
    dmdc_addr_t CPU_ADDR_IN;
    logic ROW_STROBE_BANK_LO_OUT, ROW_STROBE_BANK_HI_OUT;
    logic COL_STROBE_BANK_LO_OUT, COL_STROBE_BANK_HI_OUT;
    logic PARITY_CHECK_ENABLE_OUT, DRAM_ADDR_BIT8_OUT, DRAM_ADDR_BIT9_OUT;
    logic MEM_DATA_DIRECTION_N_OUT, WORD_ACCESS_FLAG_OUT, NMI_OUT;
    logic LOW_MEG_SELECT_N_OUT, ROM_SELECT_LOW_N_OUT, ROM_SELECT_HIGH_N_OUT;
    logic GATED_ADDR_BIT20_OUT, SLOT_ADDR_OE_OUT, ADDR_ENABLE_OUT;
    logic [6:0] SLOT_ADDR_HI_OUT;
    logic [7:0] CTRL_READBACK_OUT;
    int n_mismatch = 0;
    int checked = 0;
    always #10 MCLK_IN = ~MCLK_IN;
    dmdc_top i_dut (.*);
    dmdc_bus_model i_bus (.clk_in(MCLK_IN), .addr_out(CPU_ADDR_IN),
        .ale_out(ADDR_LATCH_STROBE_IN), .ram_ale_out(RAM_LATCH_STROBE_IN),
        .fast_out(FAST_TIMING_MODE_IN));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK_IN);
        #1;
    endtask : tick
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    task automatic reset_dut(input logic [2:0] cfg);
        SRST_IN = 1'b1;
        {RAM_CONFIG_SEL_BIT2_IN, RAM_CONFIG_SEL_BIT1_IN,
         RAM_CONFIG_SEL_BIT0_IN} = cfg;
        tick(16);
        SRST_IN = 1'b0;
        tick(8);
    endtask : reset_dut
    task automatic t_map();
        MEM_WORD_IN = 1'b1;
        MEM_READ_IN = 1'b1;
        i_bus.cycle(24'h00_0100, 1'b0);
        check({ROW_STROBE_BANK_LO_OUT, ROW_STROBE_BANK_HI_OUT,
            COL_STROBE_BANK_LO_OUT, LOW_MEG_SELECT_N_OUT}, 4'hA, "low");
        check({WORD_ACCESS_FLAG_OUT, MEM_DATA_DIRECTION_N_OUT}, 2'h3, "wd");
        MEM_WORD_IN = 1'b0;
        MEM_READ_IN = 1'b0;
        i_bus.cycle(24'h10_0000, 1'b0);
        check({ROW_STROBE_BANK_LO_OUT, ROW_STROBE_BANK_HI_OUT,
            COL_STROBE_BANK_HI_OUT, LOW_MEG_SELECT_N_OUT}, 4'h7, "hi");
        check(SLOT_ADDR_HI_OUT, 7'h08, "slot");
        i_bus.cycle(24'h04_0000, 1'b1);
        check({ROW_STROBE_BANK_LO_OUT, SLOT_ADDR_HI_OUT}, 8'h82, "fast");
        check(DRAM_ADDR_BIT9_OUT, 1'b1, "ma9");
        $display("t_map done");
    endtask : t_map
    task automatic t_rom();
        i_bus.cycle(24'h0E_0000, 1'b0);
        check({ROM_SELECT_LOW_N_OUT, ROM_SELECT_HIGH_N_OUT,
            ROW_STROBE_BANK_LO_OUT, LOW_MEG_SELECT_N_OUT}, 4'h4, "rlo");
        PERIPH_ADDR_BIT16_IN = 1'b1;
        tick(3);
        i_bus.cycle(24'h0F_0000, 1'b0);
        tick(2);
        check({ROM_SELECT_LOW_N_OUT, ROM_SELECT_HIGH_N_OUT}, 2'h2, "rhi");
        $display("t_rom done");
    endtask : t_rom
    task automatic t_refresh();
        REFRESH_ROW_BIT9_IN = 1'b1;
        REFRESH_REQ_N_IN = 1'b0;
        tick(6);
        check({ROW_STROBE_BANK_LO_OUT, ROW_STROBE_BANK_HI_OUT,
            PARITY_CHECK_ENABLE_OUT, DRAM_ADDR_BIT8_OUT}, 4'hD, "ref");
        REFRESH_ROW_BIT9_IN = 1'b0;
        i_bus.cycle(24'h10_0000, 1'b0);
        check({DRAM_ADDR_BIT8_OUT, SLOT_ADDR_HI_OUT}, 8'h07, "rbit");
        REFRESH_REQ_N_IN = 1'b1;
        tick(8);
        check(ROW_STROBE_BANK_HI_OUT, 1'b0, "ref end");
        $display("t_refresh done");
    endtask : t_refresh
    task automatic t_cfg();
        for (int c = 0; c < 8; c++) begin
            reset_dut(c[2:0]);
            i_bus.cycle(24'h00_0100, 1'b0);
            check(ROW_STROBE_BANK_LO_OUT, c < 5, "cfg");
            if (c == 3) begin
                i_bus.cycle(24'h30_0000, 1'b0);
                check({ROW_STROBE_BANK_HI_OUT, DRAM_ADDR_BIT9_OUT,
                    DRAM_ADDR_BIT8_OUT}, 3'h7, "cfg3");
            end
        end
        $display("t_cfg done");
    endtask : t_cfg
    task automatic t_nmi();
        int i;
        NMI_ENABLE_IN = 1'b1;
        CHANNEL_CHECK_N_IN = 1'b0;
        for (i = 0; i < 8 && NMI_OUT !== 1'b1; i++) tick(1);
        if (NMI_OUT !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        check(CTRL_READBACK_OUT[6], 1'b1, "chk");
        CHANNEL_CHECK_N_IN = 1'b1;
        PARITY_CHECK_ON_IN = 1'b1;
        PARITY_FAULT_N_IN = 1'b0;
        TIMER_CH2_LEVEL_IN = 1'b1;
        tick(5);
        check({NMI_OUT, CTRL_READBACK_OUT[7:5]}, 4'hD, "par");
        NMI_ENABLE_IN = 1'b0;
        tick(3);
        check(NMI_OUT, 1'b0, "mask");
        $display("t_nmi done");
    endtask : t_nmi
    task automatic t_a20();
        for (int k = 0; k < 4; k++) begin
            {ADDR_BIT20_GATE_IN, CPU_ADDR_BIT20_IN} = k[1:0];
            tick(1);
            check(GATED_ADDR_BIT20_OUT, k == 3, "a20");
        end
        $display("t_a20 done");
    endtask : t_a20
    task automatic t_owner();
        check({SLOT_ADDR_OE_OUT, ADDR_ENABLE_OUT}, 2'h3, "own");
        CPU_HOLD_ACK_IN = 1'b1;
        tick(1);
        check(ADDR_ENABLE_OUT, 1'b0, "hlda");
        CPU_HOLD_ACK_IN = 1'b0;
        BUS_OWNER_N_IN = 1'b0;
        tick(3);
        check({SLOT_ADDR_OE_OUT, ADDR_ENABLE_OUT}, 2'h0, "mst");
        BUS_OWNER_N_IN = 1'b1;
        DMA_ADDR_ACTIVE_N_IN = 1'b0;
        tick(3);
        check({SLOT_ADDR_OE_OUT, ADDR_ENABLE_OUT}, 2'h2, "dma");
        DMA_ADDR_ACTIVE_N_IN = 1'b1;
        tick(3);
        check(ADDR_ENABLE_OUT, 1'b1, "cpu");
        $display("t_owner done");
    endtask : t_owner
    initial begin
        {CE_IN, CPU_HOLD_ACK_IN, BUS_OWNER_N_IN} = 3'h5;
        {CPU_ADDR_BIT20_IN, ADDR_BIT20_GATE_IN, MEM_READ_IN} = 3'h0;
        {MEM_WORD_IN, PERIPH_ADDR_BIT16_IN, REFRESH_ROW_BIT9_IN} = 3'h0;
        DMA_ADDR_ACTIVE_N_IN = 1'b1;
        {REFRESH_REQ_N_IN, CHANNEL_CHECK_N_IN, PARITY_FAULT_N_IN} = 3'h7;
        {TIMER_CH2_LEVEL_IN, NMI_ENABLE_IN, PARITY_CHECK_ON_IN} = 3'h0;
        reset_dut(3'h4);
        t_map();
        t_rom();
        t_refresh();
        t_nmi();
        t_a20();
        t_owner();
        t_cfg();
        wrap_up();
    end
endmodule : dmdc_top_test
